// ==== design/lcs_pkg.sv ====
package lcs_pkg;

   // Synchronised pin inputs, one bit each in the sampled vector.
   localparam int NUM_PINS  = 8;
   localparam int PIN_VSEL  = 0;
   localparam int PIN_COND  = 1;
   localparam int PIN_TERM  = 2;
   localparam int PIN_TENTH = 3;
   localparam int PIN_RESTA = 4;
   localparam int PIN_HOT   = 5;
   localparam int PIN_SUPP  = 6;
   localparam int PIN_OSC   = 7;

   localparam int TMR_W = 24;

   // Base period in timer-oscillator ticks (arbitrary default).
   localparam int T0_TICKS_DEF = 1200;

   // Timer runs in half ticks so that thermal stretching can halve its rate.
   localparam int          COND_HALVES = 2;
   localparam int          BULK_HALVES = 3;
   localparam int          FIN_HALVES  = 6;
   localparam logic [TMR_W-1:0] STEP_COOL = 24'h000002;
   localparam logic [TMR_W-1:0] STEP_HOT  = 24'h000001;
   localparam logic [TMR_W-1:0] TMR_ZERO  = 24'h000000;

   // Register byte addresses.
   localparam int          ADR_W     = 8;
   localparam logic [7:0]  ADR_CTRL  = 8'h00;
   localparam logic [7:0]  ADR_STAT  = 8'h04;
   localparam logic [7:0]  ADR_TIMER = 8'h08;

   // Control register fields.
   localparam int          CTRL_INHIBIT = 0;
   localparam logic        CTRL_RST     = 1'b0;

   // Status register fields.
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_CV        = 8;
   localparam int STAT_HOT       = 9;
   localparam int STAT_TERM42    = 10;
   localparam int STAT_SUPPLY    = 11;

   typedef enum logic [5:0] {
      LCS_SUSP   = 6'h01,
      LCS_COND   = 6'h02,
      LCS_BULK   = 6'h04,
      LCS_FINISH = 6'h08,
      LCS_DONE   = 6'h10,
      LCS_FAULT  = 6'h20
   } lcs_state_t;

   typedef enum logic [1:0] {
      LCS_SEL_NONE  = 2'h0,
      LCS_SEL_CTRL  = 2'h1,
      LCS_SEL_STAT  = 2'h2,
      LCS_SEL_TIMER = 2'h3
   } lcs_reg_t;

   function automatic lcs_reg_t lcs_decode(input logic [7:0] adr);
      case (adr)
         ADR_CTRL:  lcs_decode = LCS_SEL_CTRL;
         ADR_STAT:  lcs_decode = LCS_SEL_STAT;
         ADR_TIMER: lcs_decode = LCS_SEL_TIMER;
         default:   lcs_decode = LCS_SEL_NONE;
      endcase
   endfunction

endpackage

// ==== design/lcs_sequencer.sv ====
// Behaviour
// R01 - Select 4.10V when select pin low, 4.20V when high above threshold.
// R02 - Request charge current reduction while the die runs hot.
// R03 - Stretch every safety timeout under thermal limiting, never beyond twice.
// R04 - Each new cycle starts in conditioning until battery exceeds threshold.
// R05 - Conditioning charges at one tenth of the fast-charge current.
// R06 - Reaching the conditioning threshold moves conditioning to bulk charge.
// R07 - Conditioning timeout without reaching threshold enters fault.
// R08 - Bulk starts constant current, switches to constant voltage at termination.
// R09 - In constant voltage, current at one tenth moves bulk to finish.
// R10 - Bulk timeout of one and a half base periods enters fault.
// R11 - Finish keeps constant voltage; incomplete at its timeout enters fault.
// R12 - Finish shows completion; after its delay charging stops entirely.
// R13 - Charge-done presents high impedance and keeps watching cell voltage.
// R14 - Charge-done restarts directly in bulk when cell sags below restart level.
// R15 - Fault releases both indicator outputs.
// R16 - Fault is left only by power-on reset.
// R17 - Timeouts are one, one and a half and three base periods.
// R18 - Status on in conditioning and bulk; done on in delay and done.
// R19 - Low or reversed input supply suspends and stops battery drain.
// R20 - Analog flags arrive synchronised; timeouts count timer-oscillator ticks.
// R21 - Reset leaves conditioning state with all safety timers cleared.
`timescale 1ns/1ps
module lcs_sequencer
   import lcs_pkg::*;
#(
   parameter int T0_TICKS = T0_TICKS_DEF
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        term_voltage_select_i,
   input  wire logic        above_cond_i,
   input  wire logic        term_reached_i,
   input  wire logic        current_tenth_i,
   input  wire logic        restart_level_i,
   input  wire logic        thermal_hot_i,
   input  wire logic        supply_ok_i,
   input  wire logic        timer_osc_i,
   output logic             term_4v2_o,
   output logic             charge_enable_o,
   output logic             precond_current_o,
   output logic             cv_mode_o,
   output logic             thermal_reduce_o,
   output logic             battery_hiz_o,
   output logic             charge_status_indicator_o,
   output logic             charge_status_indicator_oe_o,
   output logic             charge_done_indicator_o,
   output logic             charge_done_indicator_oe_o
);

   localparam logic [TMR_W-1:0] COND_LIM = TMR_W'(T0_TICKS * COND_HALVES);
   localparam logic [TMR_W-1:0] BULK_LIM = TMR_W'(T0_TICKS * BULK_HALVES);
   localparam logic [TMR_W-1:0] FIN_LIM  = TMR_W'(T0_TICKS * FIN_HALVES);

   logic [NUM_PINS-1:0] pins_raw;
   logic [NUM_PINS-1:0] meta_ff;
   logic [NUM_PINS-1:0] sync_ff;
   logic                osc_d_ff;
   logic                tick;
   lcs_state_t          state_ff;
   lcs_state_t          nxt_state;
   logic                cv_ff;
   logic                nxt_cv;
   logic [TMR_W-1:0]    tmr_ff;
   logic [TMR_W-1:0]    nxt_tmr;
   logic [TMR_W-1:0]    tmr_lim;
   logic                tmr_exp;
   logic                inhibit_ff;
   logic                ack_ff;
   logic [31:0]         rdata_ff;
   logic                status_oe_ff;
   logic                done_oe_ff;
   logic                term_ff;
   logic                chg_en_ff;
   logic                precond_ff;
   logic                cvout_ff;
   logic                hot_out_ff;
   logic                hiz_ff;
   logic                wb_req;
   lcs_reg_t            wb_reg;

   assign pins_raw = {timer_osc_i, supply_ok_i, thermal_hot_i, restart_level_i,
                      current_tenth_i, term_reached_i, above_cond_i,
                      term_voltage_select_i};

   // Two-stage synchronisers; only sync_ff is read by logic.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               meta_ff[gi] <= 1'b0;
               sync_ff[gi] <= 1'b0;
            end else begin
               meta_ff[gi] <= pins_raw[gi]; // R20
               sync_ff[gi] <= meta_ff[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_d_ff <= 1'b0;
      end else begin
         osc_d_ff <= sync_ff[PIN_OSC];
      end
   end

   assign tick = sync_ff[PIN_OSC] & ~osc_d_ff; // R20

   always_comb begin
      case (state_ff)
         LCS_COND:   tmr_lim = COND_LIM; // R17
         LCS_BULK:   tmr_lim = BULK_LIM; // R17
         LCS_FINISH: tmr_lim = FIN_LIM;  // R17
         default:    tmr_lim = FIN_LIM;
      endcase
   end

   assign tmr_exp = (tmr_ff >= tmr_lim);

   // Charge state machine.
   always_comb begin
      nxt_state = state_ff;
      if (state_ff == LCS_FAULT) begin
         nxt_state = LCS_FAULT; // R16
      end else if (!sync_ff[PIN_SUPP] || inhibit_ff) begin
         nxt_state = LCS_SUSP; // R19
      end else begin
         case (state_ff)
            LCS_SUSP: begin
               nxt_state = LCS_COND; // R04
            end
            LCS_COND: begin
               if (sync_ff[PIN_COND]) begin
                  nxt_state = LCS_BULK; // R06
               end else if (tmr_exp) begin
                  nxt_state = LCS_FAULT; // R07
               end
            end
            LCS_BULK: begin
               if (cv_ff && sync_ff[PIN_TENTH]) begin
                  nxt_state = LCS_FINISH; // R09
               end else if (tmr_exp) begin
                  nxt_state = LCS_FAULT; // R10
               end
            end
            LCS_FINISH: begin
               if (tmr_exp) begin
                  nxt_state = sync_ff[PIN_TENTH] ? LCS_DONE : LCS_FAULT; // R11 R12
               end
            end
            LCS_DONE: begin
               if (sync_ff[PIN_RESTA]) begin
                  nxt_state = LCS_BULK; // R14
               end
            end
            default: begin
               nxt_state = LCS_FAULT;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= LCS_COND; // R21
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Constant-voltage phase latches once termination is reached in bulk.
   always_comb begin
      nxt_cv = cv_ff;
      if (nxt_state != LCS_BULK) begin
         nxt_cv = 1'b0;
      end else if (state_ff == LCS_BULK && sync_ff[PIN_TERM]) begin
         nxt_cv = 1'b1; // R08
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cv_ff <= 1'b0;
      end else begin
         cv_ff <= nxt_cv;
      end
   end

   // Safety timer in half ticks; a hot die halves its rate, which at most doubles it.
   always_comb begin
      nxt_tmr = tmr_ff;
      if (nxt_state != state_ff) begin
         nxt_tmr = TMR_ZERO;
      end else if (tick && !tmr_exp) begin
         nxt_tmr = tmr_ff + (sync_ff[PIN_HOT] ? STEP_HOT : STEP_COOL); // R03
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tmr_ff <= TMR_ZERO; // R21
      end else begin
         tmr_ff <= nxt_tmr;
      end
   end

   // State-decoded outputs follow the next state so they line up with state_ff; thermal and select register sync_ff.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_oe_ff <= 1'b0;
         done_oe_ff   <= 1'b0;
         chg_en_ff    <= 1'b0;
         precond_ff   <= 1'b0;
         cvout_ff     <= 1'b0;
         hiz_ff       <= 1'b1;
         hot_out_ff   <= 1'b0;
         term_ff      <= 1'b0;
      end else begin
         status_oe_ff <= (nxt_state == LCS_COND) || (nxt_state == LCS_BULK); // R18 R15
         done_oe_ff   <= (nxt_state == LCS_FINISH) || (nxt_state == LCS_DONE); // R18 R12
         chg_en_ff    <= (nxt_state == LCS_COND) || (nxt_state == LCS_BULK) ||
                         (nxt_state == LCS_FINISH); // R12
         precond_ff   <= (nxt_state == LCS_COND); // R05
         cvout_ff     <= nxt_cv || (nxt_state == LCS_FINISH); // R08 R11
         hiz_ff       <= (nxt_state == LCS_DONE) || (nxt_state == LCS_FAULT) ||
                         (nxt_state == LCS_SUSP); // R13 R19
         hot_out_ff   <= sync_ff[PIN_HOT]; // R02
         term_ff      <= sync_ff[PIN_VSEL]; // R01
      end
   end

   assign charge_status_indicator_o    = 1'b0;
   assign charge_status_indicator_oe_o = status_oe_ff;
   assign charge_done_indicator_o      = 1'b0;
   assign charge_done_indicator_oe_o   = done_oe_ff;
   assign charge_enable_o              = chg_en_ff;
   assign precond_current_o            = precond_ff;
   assign cv_mode_o                    = cvout_ff;
   assign battery_hiz_o                = hiz_ff;
   assign thermal_reduce_o             = hot_out_ff;
   assign term_4v2_o                   = term_ff;

   // Wishbone classic slave, one wait state, unmapped reads return zero.
   assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wb_reg = lcs_decode(wb_adr_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= wb_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         inhibit_ff <= CTRL_RST;
      end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_reg == LCS_SEL_CTRL) begin
         inhibit_ff <= wb_dat_i[CTRL_INHIBIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_ff <= 32'h00000000;
      end else if (wb_req && !wb_we_i) begin
         rdata_ff <= 32'h00000000;
         case (wb_reg)
            LCS_SEL_CTRL: begin
               rdata_ff[CTRL_INHIBIT] <= inhibit_ff;
            end
            LCS_SEL_STAT: begin
               rdata_ff[STAT_STATE_LSB +: $bits(lcs_state_t)] <= state_ff;
               rdata_ff[STAT_CV]             <= cv_ff;
               rdata_ff[STAT_HOT]            <= sync_ff[PIN_HOT];
               rdata_ff[STAT_TERM42]         <= term_ff;
               rdata_ff[STAT_SUPPLY]         <= sync_ff[PIN_SUPP];
            end
            LCS_SEL_TIMER: begin
               rdata_ff[TMR_W-1:0] <= tmr_ff;
            end
            default: begin
               rdata_ff <= 32'h00000000;
            end
         endcase
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdata_ff;

   property p_fault_sticky;
      @(posedge clk_i) disable iff (rst_i)
      state_ff == LCS_FAULT |=> state_ff == LCS_FAULT [*4];
   endproperty
   a_fault_sticky: assert property (p_fault_sticky) // R16
      else $error("fault state was left");

   property p_fault_release;
      @(posedge clk_i) disable iff (rst_i)
      state_ff == LCS_FAULT |-> !charge_status_indicator_oe_o && !charge_done_indicator_oe_o
                                && !charge_enable_o;
   endproperty
   a_fault_release: assert property (p_fault_release) // R15
      else $error("indicator driven in fault");

   property p_cond_timeout;
      @(posedge clk_i) disable iff (rst_i)
      state_ff == LCS_COND && tmr_ff >= COND_LIM && !sync_ff[PIN_COND] &&
      sync_ff[PIN_SUPP] && !inhibit_ff |=> state_ff == LCS_FAULT;
   endproperty
   a_cond_timeout: assert property (p_cond_timeout) // R07
      else $error("conditioning timeout missed");

   property p_bulk_timeout;
      @(posedge clk_i) disable iff (rst_i)
      state_ff == LCS_BULK && tmr_ff >= BULK_LIM && !(cv_ff && sync_ff[PIN_TENTH]) &&
      sync_ff[PIN_SUPP] && !inhibit_ff |=> state_ff == LCS_FAULT;
   endproperty
   a_bulk_timeout: assert property (p_bulk_timeout) // R10
      else $error("bulk timeout missed");

   property p_cond_advance;
      @(posedge clk_i) disable iff (rst_i)
      state_ff == LCS_COND && sync_ff[PIN_COND] && sync_ff[PIN_SUPP] && !inhibit_ff
      |=> state_ff == LCS_BULK ##1 !precond_current_o;
   endproperty
   a_cond_advance: assert property (p_cond_advance) // R06
      else $error("conditioning did not advance to bulk");

   property p_restart;
      @(posedge clk_i) disable iff (rst_i)
      state_ff == LCS_DONE && sync_ff[PIN_RESTA] && sync_ff[PIN_SUPP] && !inhibit_ff
      |=> state_ff == LCS_BULK && charge_enable_o && !battery_hiz_o;
   endproperty
   a_restart: assert property (p_restart) // R14
      else $error("restart from done failed");

   property p_timer_limit;
      @(posedge clk_i) disable iff (rst_i)
      tmr_ff <= FIN_LIM;
   endproperty
   a_timer_limit: assert property (p_timer_limit) // R03
      else $error("safety timer overran its limit");

   property p_hot_rate;
      @(posedge clk_i) disable iff (rst_i)
      tick && sync_ff[PIN_HOT] && !tmr_exp && nxt_state == state_ff
      |=> tmr_ff == $past(tmr_ff) + STEP_HOT;
   endproperty
   a_hot_rate: assert property (p_hot_rate) // R03
      else $error("hot timer rate wrong");

   // The registered indicators keep their reset value for one edge after reset.
   property p_indicators;
      @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |->
      charge_status_indicator_oe_o == (state_ff == LCS_COND || state_ff == LCS_BULK) &&
      charge_done_indicator_oe_o == (state_ff == LCS_FINISH || state_ff == LCS_DONE);
   endproperty
   a_indicators: assert property (p_indicators) // R18
      else $error("indicator does not match state");

   property p_suspend;
      @(posedge clk_i) disable iff (rst_i)
      !sync_ff[PIN_SUPP] && state_ff != LCS_FAULT |=> state_ff == LCS_SUSP && battery_hiz_o;
   endproperty
   a_suspend: assert property (p_suspend) // R19
      else $error("no suspend on supply loss");

   property p_term_sel;
      @(posedge clk_i) disable iff (rst_i)
      $rose(sync_ff[PIN_VSEL]) |=> term_4v2_o;
   endproperty
   a_term_sel: assert property (p_term_sel) // R01
      else $error("termination select not followed");

   property p_ack;
      @(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack)
      else $error("wishbone ack timing wrong");

endmodule

// ==== test/lcs_battery_model.sv ====
`timescale 1ns/1ps
module lcs_battery_model (
   input  wire logic [2:0] level_i,
   input  wire logic       status_val_i,
   input  wire logic       status_oe_i,
   input  wire logic       done_val_i,
   input  wire logic       done_oe_i,
   output logic            above_cond_o,
   output logic            term_reached_o,
   output logic            current_tenth_o,
   output logic            restart_level_o,
   output logic            status_led_o,
   output logic            done_led_o
);
   // Cell level: 0 deep, 1 above threshold, 2 at termination, 3 tapered, 4 sagged.
   assign above_cond_o    = (level_i != 3'h0);
   assign term_reached_o  = (level_i == 3'h2) || (level_i == 3'h3);
   assign current_tenth_o = (level_i == 3'h3);
   assign restart_level_o = (level_i == 3'h4);
   // Each pin has a pull-up, so an LED lights only while its pin sinks current.
   assign status_led_o = status_oe_i && (status_val_i === 1'h0);
   assign done_led_o   = done_oe_i && (done_val_i === 1'h0);
endmodule

// ==== test/li_cell_charge_sequencer_test.sv ====
`timescale 1ns/1ps
module li_cell_charge_sequencer_test;
   import lcs_pkg::*;
   localparam int T0 = 4;
   typedef struct {
      logic       sup;
      logic       vsel;
      logic [2:0] lvl;
      int         wait_n;
      lcs_state_t st;
      logic       cv;
   } lcs_row_t;
   logic        clk_i  = 1'h0;
   logic        rst_i  = 1'h1;
   logic        cyc    = 1'h0;
   logic        stb    = 1'h0;
   logic        we     = 1'h0;
   logic [7:0]  adr    = 8'h00;
   logic [3:0]  sel    = 4'h0;
   logic [31:0] wdat   = 32'h00000000;
   logic        vsel   = 1'h0;
   logic        hot    = 1'h0;
   logic        sup    = 1'h1;
   logic        osc    = 1'h0;
   logic        osc_en = 1'h0;
   logic [2:0]  lvl    = 3'h0;
   int          osc_cnt = 0;
   int          n_fail  = 0;
   int          total_checks = 0;
   logic [31:0] rdat, d;
   logic        ack, above, termr, tenth, restart, t42, en, pre, cv, thr, hiz;
   logic        s_val, s_oe, e_val, e_oe, status_led, done_led;
   lcs_row_t    rows[8];

   lcs_sequencer #(.T0_TICKS(T0)) i_lcs_sequencer (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .term_voltage_select_i(vsel), .above_cond_i(above), .term_reached_i(termr),
      .current_tenth_i(tenth), .restart_level_i(restart), .thermal_hot_i(hot),
      .supply_ok_i(sup), .timer_osc_i(osc), .term_4v2_o(t42), .charge_enable_o(en),
      .precond_current_o(pre), .cv_mode_o(cv), .thermal_reduce_o(thr),
      .battery_hiz_o(hiz), .charge_status_indicator_o(s_val),
      .charge_status_indicator_oe_o(s_oe), .charge_done_indicator_o(e_val),
      .charge_done_indicator_oe_o(e_oe));

   lcs_battery_model i_lcs_battery_model (
      .level_i(lvl), .status_val_i(s_val), .status_oe_i(s_oe), .done_val_i(e_val),
      .done_oe_i(e_oe), .above_cond_o(above), .term_reached_o(termr),
      .current_tenth_o(tenth), .restart_level_o(restart), .status_led_o(status_led),
      .done_led_o(done_led));

   initial begin
      forever #2 clk_i = ~clk_i;
   end

   // Timer oscillator: one rising edge every 20 clock cycles while enabled.
   always @(posedge clk_i) begin
      if (osc_en) begin
         if (osc_cnt == 9) begin
            osc_cnt <= 0;
            osc <= ~osc;
         end else begin
            osc_cnt <= osc_cnt + 1;
         end
      end
   end

   task automatic summarize();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      #40000;
      n_fail++;
      $display("[FAIL] watchdog expired");
      summarize();
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chkb(input string name, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
      int n;
      @(posedge clk_i);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= wd;
      sel <= 4'hF;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'h1);
      chk("bus ack latency", 32'h00000002, n);
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
   endtask

   task automatic drive(input logic s, input logic v, input logic h, input logic [2:0] l);
      @(posedge clk_i);
      sup <= s;
      vsel <= v;
      hot <= h;
      lvl <= l;
   endtask

   task automatic do_reset();
      @(posedge clk_i);
      rst_i <= 1'h1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'h0;
   endtask

   task automatic expect_state(input lcs_state_t s);
      logic [31:0] q;
      wb(1'h0, ADR_STAT, 32'h00000000, q);
      chk("state", {26'h0000000, s}, {26'h0000000, q[5:0]});
      chkb("status led", s inside {LCS_COND, LCS_BULK}, status_led);
      chkb("done led", s inside {LCS_FINISH, LCS_DONE}, done_led);
      chkb("battery hiz", s inside {LCS_SUSP, LCS_DONE, LCS_FAULT}, hiz);
      chkb("charge enable", s inside {LCS_COND, LCS_BULK, LCS_FINISH}, en);
      chkb("precondition", s == LCS_COND, pre);
   endtask

   initial begin
      rows[0] = '{1'h1, 1'h0, 3'h0, 10, LCS_COND, 1'h0};
      rows[1] = '{1'h1, 1'h1, 3'h1, 10, LCS_BULK, 1'h0};
      rows[2] = '{1'h1, 1'h1, 3'h2, 10, LCS_BULK, 1'h1};
      rows[3] = '{1'h1, 1'h1, 3'h3, 10, LCS_FINISH, 1'h1};
      rows[4] = '{1'h1, 1'h1, 3'h3, 300, LCS_DONE, 1'h0};
      rows[5] = '{1'h1, 1'h1, 3'h4, 10, LCS_BULK, 1'h0};
      rows[6] = '{1'h0, 1'h1, 3'h4, 10, LCS_SUSP, 1'h0};
      rows[7] = '{1'h1, 1'h0, 3'h0, 10, LCS_COND, 1'h0};
      do_reset();
      wb(1'h0, ADR_TIMER, 32'h00000000, d);
      chk("timer after reset", 32'h00000000, d);
      wb(1'h0, ADR_CTRL, 32'h00000000, d);
      chk("control after reset", {31'h00000000, CTRL_RST}, d);
      expect_state(LCS_COND);
      $display("test reset done");
      @(posedge clk_i);
      osc_en <= 1'h1;
      for (int i = 0; i < 8; i++) begin
         drive(rows[i].sup, rows[i].vsel, 1'h0, rows[i].lvl);
         repeat (rows[i].wait_n) @(posedge clk_i);
         chkb("termination select", rows[i].vsel, t42);
         chkb("constant voltage", rows[i].cv, cv);
         expect_state(rows[i].st);
         wb(1'h0, ADR_STAT, 32'h00000000, d);
         chk("status word", {20'h00000, rows[i].sup, rows[i].vsel, 1'h0,
             (rows[i].cv && rows[i].st == LCS_BULK), 2'h0, rows[i].st}, d);
      end
      $display("test charge sequence done");
      drive(1'h1, 1'h0, 1'h0, 3'h0);
      do_reset();
      repeat (50) @(posedge clk_i);
      expect_state(LCS_COND);
      repeat (60) @(posedge clk_i);
      expect_state(LCS_FAULT);
      drive(1'h0, 1'h1, 1'h0, 3'h1);
      repeat (10) @(posedge clk_i);
      expect_state(LCS_FAULT);
      $display("test conditioning timeout done");
      drive(1'h1, 1'h0, 1'h1, 3'h0);
      do_reset();
      repeat (130) @(posedge clk_i);
      expect_state(LCS_COND);
      chkb("thermal reduce", 1'h1, thr);
      repeat (70) @(posedge clk_i);
      expect_state(LCS_FAULT);
      $display("test thermal stretch done");
      drive(1'h1, 1'h0, 1'h0, 3'h1);
      do_reset();
      repeat (80) @(posedge clk_i);
      expect_state(LCS_BULK);
      repeat (60) @(posedge clk_i);
      expect_state(LCS_FAULT);
      $display("test bulk timeout done");
      drive(1'h1, 1'h1, 1'h0, 3'h3);
      do_reset();
      repeat (10) @(posedge clk_i);
      expect_state(LCS_FINISH);
      drive(1'h1, 1'h1, 1'h0, 3'h2);
      repeat (300) @(posedge clk_i);
      expect_state(LCS_FAULT);
      $display("test finish timeout done");
      drive(1'h1, 1'h0, 1'h0, 3'h0);
      do_reset();
      wb(1'h1, ADR_CTRL, 32'h00000001, d);
      repeat (10) @(posedge clk_i);
      expect_state(LCS_SUSP);
      wb(1'h0, ADR_CTRL, 32'h00000000, d);
      chk("control readback", 32'h00000001, d);
      wb(1'h1, ADR_STAT, 32'hFFFFFFFF, d);
      wb(1'h0, 8'h0C, 32'h00000000, d);
      chk("unmapped read", 32'h00000000, d);
      wb(1'h1, ADR_CTRL, 32'h00000000, d);
      repeat (10) @(posedge clk_i);
      expect_state(LCS_COND);
      $display("test registers done");
      summarize();
   end
endmodule
